//--- verilog/docc_defs.vh
// Purpose: constants for the digital output channel controller
// Assumes: 100 MHz clock, byte addresses on the register port
// Notes:   definitions only, no logic
`ifndef DOCC_DEFS_VH
`define DOCC_DEFS_VH

// timing
`define DOCC_CLK_NS      10
`define DOCC_MS_NS       1000000

// register byte offsets
`define DOCC_CTRL        8'h00
`define DOCC_ON_DLY      8'h04
`define DOCC_OFF_DLY     8'h08
`define DOCC_WDOG        8'h0c
`define DOCC_STATUS      8'h10
`define DOCC_IRQ_STAT    8'h14
`define DOCC_IRQ_MASK    8'h18

// control register fields
`define DOCC_C_SIM       0
`define DOCC_C_ERR_LO    1
`define DOCC_C_ERR_HI    2
`define DOCC_C_INV       3
`define DOCC_C_LMON      4
`define DOCC_C_SIMVAL    5
`define DOCC_C_SIMBAD    6
`define DOCC_C_SUBVAL    7
`define DOCC_CTRL_W      8
`define DOCC_CTRL_RST    8'h00

// error mode codes
`define DOCC_EM_PASS     2'h0
`define DOCC_EM_SUBST    2'h1
`define DOCC_EM_HOLD     2'h2

// interrupt bits
`define DOCC_I_FAULT     0
`define DOCC_I_LINE      1
`define DOCC_I_WDOG      2
`define DOCC_IRQ_W       3

// delay and watchdog reset values, in ms
`define DOCC_DLY_RST     16'h0000
`define DOCC_WDOG_RST    16'h0000

`endif

//--- verilog/docc_ctrl.v
// Purpose: one digital output channel: source select, fault strategy,
//          inversion, on/off delay filters, line fault flag, irq
// Assumes: all inputs synchronous to clk, cmd_stb marks each new
//          command from the com unit
// Notes:   register port answers reads one cycle later, never stalls
//
// What this block does
// [RL1] normal mode outputs processed bus command bit
// [RL2] simulation mode outputs configured simulated bit
// [RL3] watchdog expiry or invalid status enters fault
// [RL4] line faults never trigger fault strategy
// [RL5] pass-through strategy forwards incoming bit unchanged
// [RL6] replacement strategy drives fixed substitute bit
// [RL7] hold strategy keeps last valid bit
// [RL8] inversion setting negates processed bit
// [RL9] line monitoring flags breakage or short
// [RL10] channel active follows module activation only
// [RL11] substitute bit 0/1, always marked invalid
// [RL12] off delay postpones 1 to 0 changes
// [RL13] on delay filters short high pulses
// [RL14] fault ends when watchdog and status recover
// [RL15] order: select, fault, invert, delay filters
`timescale 1ns/1ps
`include "docc_defs.vh"

module docc_ctrl #(
  parameter MS_CYC = `DOCC_MS_NS / `DOCC_CLK_NS, // clock cycles per ms
  parameter DLY_W  = 16                          // ms counter width
) (
  // clock and reset
  input  wire        clk,
  input  wire        rst,
  // register port
  input  wire [7:0]  addr,
  input  wire [31:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [31:0] rdata,
  // command from the com unit
  input  wire        cmd_stb,
  input  wire        cmd_bit,
  input  wire        cmd_invalid,
  // module level activation
  input  wire        module_active,
  // field circuit sense
  input  wire        line_open,
  input  wire        line_short,
  // field side and status
  output reg         field_out,
  output reg         pv_invalid,
  output reg         line_fault,
  output reg         chan_active,
  output reg         irq
);

  // ms tick divider width, wide enough for the default count
  localparam DIV_W = 24;
  // integer count cut to the divider width on purpose
  localparam integer     DIV_LAST_I = MS_CYC - 1;
  localparam [DIV_W-1:0] DIV_LAST   = DIV_LAST_I[DIV_W-1:0];

  // configuration registers
  reg [`DOCC_CTRL_W-1:0] ctrl_r;     // mode and strategy bits
  reg [DLY_W-1:0]        on_dly_r;   // turn-on delay, ms
  reg [DLY_W-1:0]        off_dly_r;  // turn-off delay, ms
  reg [DLY_W-1:0]        wdog_r;     // watchdog time, ms, 0 = off
  reg [`DOCC_IRQ_W-1:0]  istat_r;    // sticky event bits
  reg [`DOCC_IRQ_W-1:0]  imask_r;    // event enables

  // datapath state
  reg             cmd_bit_r;   // latest received command bit
  reg             cmd_bad_r;   // its invalid-data status
  reg             last_ok_r;   // last bit seen without a fault
  reg [DIV_W-1:0] div_r;       // ms divider
  reg             ms_tick_r;   // one-cycle pulse each ms
  reg [DLY_W-1:0] wd_cnt_r;    // ms since last command
  reg             wd_exp_r;    // watchdog expired
  reg [DLY_W-1:0] flt_cnt_r;   // ms the filter input has differed
  reg             fault_d_r;   // fault, one cycle ago
  reg             line_d_r;    // line fault, one cycle ago

  // control field views
  wire       sim_mode = ctrl_r[`DOCC_C_SIM];
  wire [1:0] err_mode = ctrl_r[`DOCC_C_ERR_HI:`DOCC_C_ERR_LO];
  wire       inv_en   = ctrl_r[`DOCC_C_INV];
  wire       lmon_en  = ctrl_r[`DOCC_C_LMON];
  wire       sim_val  = ctrl_r[`DOCC_C_SIMVAL];
  wire       sim_bad  = ctrl_r[`DOCC_C_SIMBAD];
  wire       sub_val  = ctrl_r[`DOCC_C_SUBVAL];

  // register decode
  wire wr_ctrl  = wr && (addr == `DOCC_CTRL);
  wire wr_on    = wr && (addr == `DOCC_ON_DLY);
  wire wr_off   = wr && (addr == `DOCC_OFF_DLY);
  wire wr_wdog  = wr && (addr == `DOCC_WDOG);
  wire wr_istat = wr && (addr == `DOCC_IRQ_STAT);
  wire wr_imask = wr && (addr == `DOCC_IRQ_MASK);

  // combinational datapath
  reg sel_bit;   // selected source bit
  reg sel_bad;   // status of the selected source
  reg fault;     // fault strategy active
  reg proc_bit;  // bit after the fault strategy
  reg proc_bad;  // status reported with it
  reg inv_bit;   // bit after inversion
  reg line_now;  // line fault seen now

  // source, fault strategy and inversion, in that order
  // [RL15] fixed stage order
  always @* begin
    // [RL1] normal: bus bit
    sel_bit = cmd_bit_r;
    sel_bad = cmd_bad_r;
    // [RL2] simulation replaces bus bit
    if (sim_mode) begin
      sel_bit = sim_val;
      sel_bad = sim_bad;
    end
    // [RL3] watchdog or invalid status
    // [RL4] line fault not part of this term
    fault = wd_exp_r | sel_bad;
    proc_bit = sel_bit;
    proc_bad = fault;
    if (fault) begin
      case (err_mode)
        // [RL5] pass-through keeps source bit
        `DOCC_EM_PASS: begin
          proc_bit = sel_bit;
        end
        // [RL6] fixed replacement bit
        // [RL11] always reported invalid
        `DOCC_EM_SUBST: begin
          proc_bit = sub_val;
          proc_bad = 1'b1;
        end
        // [RL7] last valid bit
        `DOCC_EM_HOLD: begin
          proc_bit = last_ok_r;
        end
        // unused code behaves as hold, the safer reading
        default: begin
          proc_bit = last_ok_r;
        end
      endcase
    end
    // [RL8] optional negation
    inv_bit = inv_en ? ~proc_bit : proc_bit;
    // [RL9] lead breakage or short
    line_now = lmon_en & (line_open | line_short);
  end

  // filter target: inactive channel drives a safe low
  wire filt_in = chan_active ? inv_bit : 1'b0;
  // delay that applies to the pending change
  wire [DLY_W-1:0] flt_dly = filt_in ? on_dly_r : off_dly_r;

  // capture commands from the com unit
  always @(posedge clk) begin
    if (rst) begin
      cmd_bit_r <= 1'b0;
      cmd_bad_r <= 1'b0;
    end else if (cmd_stb) begin
      cmd_bit_r <= cmd_bit;
      cmd_bad_r <= cmd_invalid;
    end
  end

  // remember the last bit that passed with no fault
  always @(posedge clk) begin
    if (rst) begin
      last_ok_r <= 1'b0;
    end else if (!fault) begin
      last_ok_r <= sel_bit;
    end
  end

  // one ms enable pulse, shared by watchdog and filters
  always @(posedge clk) begin
    if (rst) begin
      div_r     <= {DIV_W{1'b0}};
      ms_tick_r <= 1'b0;
    end else if (div_r == DIV_LAST) begin
      div_r     <= {DIV_W{1'b0}};
      ms_tick_r <= 1'b1;
    end else begin
      div_r     <= div_r + 1'b1;
      ms_tick_r <= 1'b0;
    end
  end

  // communication watchdog, restarted by every command
  // resolution is one ms, so expiry may come up to 1 ms early
  always @(posedge clk) begin
    if (rst) begin
      wd_cnt_r <= {DLY_W{1'b0}};
      wd_exp_r <= 1'b0;
    end else if (cmd_stb || wdog_r == {DLY_W{1'b0}}) begin
      // [RL14] recovery on fresh command
      wd_cnt_r <= {DLY_W{1'b0}};
      wd_exp_r <= 1'b0;
    end else if (ms_tick_r && !wd_exp_r) begin
      // [RL3] watchdog time expires
      if (wd_cnt_r + 1'b1 >= wdog_r) begin
        wd_exp_r <= 1'b1;
      end
      wd_cnt_r <= wd_cnt_r + 1'b1;
    end
  end

  // on and off delay filter in front of the pin
  // a change must stand for the whole delay, else it is dropped
  always @(posedge clk) begin
    if (rst) begin
      flt_cnt_r <= {DLY_W{1'b0}};
      field_out <= 1'b0;
    end else if (filt_in == field_out) begin
      // input back at output: restart the count
      flt_cnt_r <= {DLY_W{1'b0}};
    end else if (flt_cnt_r >= flt_dly) begin
      // [RL13] on delay elapsed
      // [RL12] off delay elapsed
      field_out <= filt_in;
      flt_cnt_r <= {DLY_W{1'b0}};
    end else if (ms_tick_r) begin
      flt_cnt_r <= flt_cnt_r + 1'b1;
    end
  end

  // status outputs
  always @(posedge clk) begin
    if (rst) begin
      pv_invalid  <= 1'b0;
      line_fault  <= 1'b0;
      chan_active <= 1'b0;
      fault_d_r   <= 1'b0;
      line_d_r    <= 1'b0;
    end else begin
      // [RL11] invalid status follows output
      pv_invalid  <= proc_bad;
      // [RL9] flag in process value status
      line_fault  <= line_now;
      // [RL10] no per-channel control
      chan_active <= module_active;
      fault_d_r   <= fault;
      line_d_r    <= line_now;
    end
  end

  // configuration writes
  always @(posedge clk) begin
    if (rst) begin
      ctrl_r    <= `DOCC_CTRL_RST;
      on_dly_r  <= `DOCC_DLY_RST;
      off_dly_r <= `DOCC_DLY_RST;
      wdog_r    <= `DOCC_WDOG_RST;
      imask_r   <= {`DOCC_IRQ_W{1'b0}};
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= wdata[`DOCC_CTRL_W-1:0];
      end
      if (wr_on) begin
        on_dly_r <= wdata[DLY_W-1:0];
      end
      if (wr_off) begin
        off_dly_r <= wdata[DLY_W-1:0];
      end
      if (wr_wdog) begin
        wdog_r <= wdata[DLY_W-1:0];
      end
      if (wr_imask) begin
        imask_r <= wdata[`DOCC_IRQ_W-1:0];
      end
    end
  end

  // interrupt events: rising edges of fault, line fault, expiry
  wire [`DOCC_IRQ_W-1:0] ev;
  assign ev[`DOCC_I_FAULT] = fault & ~fault_d_r;
  assign ev[`DOCC_I_LINE]  = line_now & ~line_d_r;
  assign ev[`DOCC_I_WDOG]  = ms_tick_r & ~wd_exp_r & ~cmd_stb &
                             (wdog_r != {DLY_W{1'b0}}) &
                             (wd_cnt_r + 1'b1 >= wdog_r);

  // sticky status, write one to clear; a new event beats the clear
  genvar gi;
  generate
    for (gi = 0; gi < `DOCC_IRQ_W; gi = gi + 1) begin : g_ist
      always @(posedge clk) begin
        if (rst) begin
          istat_r[gi] <= 1'b0;
        end else if (ev[gi]) begin
          istat_r[gi] <= 1'b1;
        end else if (wr_istat && wdata[gi]) begin
          istat_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // level interrupt, one cycle behind the status bit
  always @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(istat_r & imask_r);
    end
  end

  // read data, valid only in the cycle after rd
  always @(posedge clk) begin
    if (rst) begin
      rdata <= 32'h0000_0000;
    end else if (rd) begin
      case (addr)
        `DOCC_CTRL: begin
          rdata <= {{(32-`DOCC_CTRL_W){1'b0}}, ctrl_r};
        end
        `DOCC_ON_DLY: begin
          rdata <= {{(32-DLY_W){1'b0}}, on_dly_r};
        end
        `DOCC_OFF_DLY: begin
          rdata <= {{(32-DLY_W){1'b0}}, off_dly_r};
        end
        `DOCC_WDOG: begin
          rdata <= {{(32-DLY_W){1'b0}}, wdog_r};
        end
        `DOCC_STATUS: begin
          // live state of the channel
          rdata <= {26'h000_0000, wd_exp_r, chan_active, line_fault,
                    pv_invalid, fault, field_out};
        end
        `DOCC_IRQ_STAT: begin
          rdata <= {{(32-`DOCC_IRQ_W){1'b0}}, istat_r};
        end
        `DOCC_IRQ_MASK: begin
          rdata <= {{(32-`DOCC_IRQ_W){1'b0}}, imask_r};
        end
        // unmapped: reads as zero
        default: begin
          rdata <= 32'h0000_0000;
        end
      endcase
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

endmodule // docc_ctrl

//--- verif/docc_props.sv
// Purpose: port assertions for docc_ctrl
// Assumes: one clock, synchronous reset active high
// Notes:   status reads compare against the pins one cycle back
`timescale 1ns/1ps

module docc_props (
  // clock and reset
  input wire        clk,
  input wire        rst,
  // register port
  input wire [7:0]  addr,
  input wire        rd,
  input wire [31:0] rdata,
  // channel side
  input wire        module_active,
  input wire        line_open,
  input wire        line_short,
  input wire        field_out,
  input wire        pv_invalid,
  input wire        line_fault,
  input wire        chan_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // read of the status word
  sequence s_rd_st;
    rd && addr == 8'h10;
  endsequence

  AST_ACT_ON: assert property (module_active |=> chan_active)
    else $error("channel not active after module activation");
  AST_ACT_OFF: assert property (!module_active |=> !chan_active)
    else $error("channel active without module activation");
  AST_LF_CAUSE: assert property ($rose(line_fault) |->
    $past(line_open || line_short))
    else $error("line fault flag without sensed fault");
  AST_RD_IDLE: assert property (!rd |=> rdata == 32'h0)
    else $error("read data not zero outside read answer");
  AST_ST_OUT: assert property (s_rd_st |=> rdata[0] == $past(field_out))
    else $error("status shows wrong output bit");
  AST_ST_PVI: assert property (s_rd_st |=> rdata[2] == $past(pv_invalid))
    else $error("status shows wrong invalid flag");
  AST_ST_LF: assert property (s_rd_st |=> rdata[3] == $past(line_fault))
    else $error("status shows wrong line fault flag");
  AST_ST_ACT: assert property (s_rd_st |=> rdata[4] == $past(chan_active))
    else $error("status shows wrong active flag");
endmodule // docc_props

bind docc_ctrl docc_props u_props (.clk(clk), .rst(rst), .addr(addr),
  .rd(rd), .rdata(rdata), .module_active(module_active),
  .line_open(line_open), .line_short(line_short), .field_out(field_out),
  .pv_invalid(pv_invalid), .line_fault(line_fault),
  .chan_active(chan_active));

//--- verif/docc_com_model.sv
// Purpose: com unit model relaying command bits
// Assumes: bench calls send, one command per call
// Notes:   idle data lines flip, so stale values never look current
`timescale 1ns/1ps

module docc_com_model (
  // clock
  input wire clk,
  // command link
  output reg cmd_stb,
  output reg cmd_bit,
  output reg cmd_invalid
);
  // quiet link at start
  initial begin
    cmd_stb = 1'b0;
    cmd_bit = 1'b0;
    cmd_invalid = 1'b0;
  end

  // one strobed command, lines inverted once released
  task send(input reg b, input reg inv);
    begin
      @(posedge clk);
      cmd_stb     <= 1'b1;
      cmd_bit     <= b;
      cmd_invalid <= inv;
      @(posedge clk);
      cmd_stb     <= 1'b0;
      cmd_bit     <= ~b;
      cmd_invalid <= ~inv;
    end
  endtask
endmodule // docc_com_model

//--- verif/docc_ctrl_tb_top.sv
// Purpose: self-checking bench for docc_ctrl
// Assumes: MS_CYC of 10, so one ms is ten cycles
// Notes:   commands come from the com unit model
`timescale 1ns/1ps
`include "docc_defs.vh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin \
  error_cnt++; $display("CHECK FAILED %0t got %h exp %h", $time, g, e); \
  end end

module docc_ctrl_tb_top;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg  [7:0]  addr = 8'h00;
  reg  [31:0] wdata = 32'h0;
  reg         wr = 1'b0;
  reg         rd = 1'b0;
  reg         module_active = 1'b1;
  reg         line_open = 1'b0;
  reg         line_short = 1'b0;
  wire [31:0] rdata;
  wire        cmd_stb, cmd_bit, cmd_invalid;
  wire        field_out, pv_invalid, line_fault, chan_active, irq;
  integer     error_cnt = 0, num_checks = 0, cyc = 0, i;
  reg  [7:0]  mode_ctl [0:3];
  reg  [3:0]  e1 = 4'b1110;  // pin after 1 good then 0 bad
  reg  [3:0]  e2 = 4'b0011;  // pin after 0 good then 1 bad

  always #5 clk = ~clk;

  docc_com_model u_com (.clk(clk), .cmd_stb(cmd_stb), .cmd_bit(cmd_bit),
    .cmd_invalid(cmd_invalid));
  docc_ctrl #(.MS_CYC(10)) DUT (.clk(clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .cmd_stb(cmd_stb),
    .cmd_bit(cmd_bit), .cmd_invalid(cmd_invalid),
    .module_active(module_active), .line_open(line_open),
    .line_short(line_short), .field_out(field_out),
    .pv_invalid(pv_invalid), .line_fault(line_fault),
    .chan_active(chan_active), .irq(irq));

  task print_verdict;
    begin
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask

  // hang guard, far above the few hundred cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict;
    end
  end

  task tick(input integer n);
    repeat (n) @(posedge clk);
  endtask

  // one-cycle write strobe
  task wreg(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      addr <= a; wdata <= d; wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask

  // one-cycle read, data checked in the answer cycle only
  task rchk(input [7:0] a, input [31:0] e);
    begin
      @(posedge clk);
      addr <= a; rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      `CHK(rdata, e)
    end
  endtask

  // let a change land, then sample pin and invalid flag
  task look(input f, input p);
    begin
      tick(3);
      @(negedge clk);
      `CHK(field_out, f)
      `CHK(pv_invalid, p)
    end
  endtask

  initial begin
    mode_ctl[0] = 8'h00; mode_ctl[1] = 8'h82;
    mode_ctl[2] = 8'h84; mode_ctl[3] = 8'h86;
    tick(3);
    rst <= 1'b0;
    rchk(`DOCC_CTRL, 32'h0);
    rchk(`DOCC_STATUS, 32'h10);
    rchk(8'h20, 32'h0);
    u_com.send(1'b1, 1'b0); look(1'b1, 1'b0);
    // inversion after the strategy
    wreg(`DOCC_CTRL, 32'h08); look(1'b0, 1'b0);
    // simulated bit replaces the bus bit
    wreg(`DOCC_CTRL, 32'h21); u_com.send(1'b0, 1'b0); look(1'b1, 1'b0);
    wreg(`DOCC_CTRL, 32'h61); look(1'b1, 1'b1);
    // every fault strategy, code 3 included
    for (i = 0; i < 4; i++) begin
      wreg(`DOCC_CTRL, {24'h0, mode_ctl[i]});
      u_com.send(1'b1, 1'b0); u_com.send(1'b0, 1'b1);
      look(e1[i], 1'b1);
      u_com.send(1'b0, 1'b0); u_com.send(1'b1, 1'b1);
      look(e2[i], 1'b1);
      u_com.send(1'b0, 1'b0); look(1'b0, 1'b0);
    end
    // watchdog expiry with substitute 1, then interrupt path
    wreg(`DOCC_CTRL, 32'h82); wreg(`DOCC_WDOG, 32'h5);
    u_com.send(1'b0, 1'b0); tick(120); look(1'b1, 1'b1);
    // expired: pin, fault, invalid, active and expiry bits all set
    rchk(`DOCC_STATUS, 32'h37);
    rchk(`DOCC_WDOG, 32'h5);
    rchk(`DOCC_IRQ_STAT, 32'h5); `CHK(irq, 1'b0)
    wreg(`DOCC_IRQ_MASK, 32'h4); tick(2); `CHK(irq, 1'b1)
    wreg(`DOCC_IRQ_STAT, 32'h5); tick(2); `CHK(irq, 1'b0)
    u_com.send(1'b0, 1'b0); look(1'b0, 1'b0);
    wreg(`DOCC_WDOG, 32'h0);
    // line faults flag but leave the value alone; substitute 1 armed,
    // so a wrongly entered strategy would show on the pin
    wreg(`DOCC_CTRL, 32'h92);
    @(posedge clk) line_open <= 1'b1;
    look(1'b0, 1'b0); `CHK(line_fault, 1'b1)
    @(posedge clk) line_open <= 1'b0;
    line_short <= 1'b1;
    look(1'b0, 1'b0); `CHK(line_fault, 1'b1)
    rchk(`DOCC_IRQ_STAT, 32'h2);
    wreg(`DOCC_CTRL, 32'h0); look(1'b0, 1'b0); `CHK(line_fault, 1'b0)
    @(posedge clk) line_short <= 1'b0;
    // module deactivation forces the pin low
    u_com.send(1'b1, 1'b0); look(1'b1, 1'b0);
    @(posedge clk) module_active <= 1'b0;
    look(1'b0, 1'b0); `CHK(chan_active, 1'b0)
    @(posedge clk) module_active <= 1'b1;
    // 3 ms delays: a short pulse vanishes, a long one is stretched
    u_com.send(1'b0, 1'b0); wreg(`DOCC_ON_DLY, 32'h3);
    u_com.send(1'b1, 1'b0); tick(8);
    u_com.send(1'b0, 1'b0); tick(50); `CHK(field_out, 1'b0)
    u_com.send(1'b1, 1'b0); tick(50); `CHK(field_out, 1'b1)
    wreg(`DOCC_OFF_DLY, 32'h3); u_com.send(1'b0, 1'b0);
    tick(8); `CHK(field_out, 1'b1)
    tick(50); `CHK(field_out, 1'b0)
    print_verdict;
  end
endmodule // docc_ctrl_tb_top
